// *** rtl/scpts_clock_control.sv ***
// The strobed register port was decided locally.
`timescale 1ns/100ps
module scpts_clock_control
  import scpts_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic [7:0]        factory_trim,
  input  wire logic              boot_divide_by_eight_fuse,
  input  wire logic              sleep_instr,
  input  wire logic              external_irq_line,
  input  wire logic              irq_level_mode,
  input  wire logic              pin_change_wake,
  input  wire logic              watchdog_wake,
  input  wire logic              nvm_ready_wake,
  input  wire logic              adc_done_wake,
  input  wire logic              other_io_wake,
  output logic      [7:0]        rc_osc_trim,
  output logic                   sys_tick,
  output logic                   cpu_clk_en,
  output logic                   flash_clk_en,
  output logic                   io_clk_en,
  output logic                   adc_clk_en,
  output logic                   osc_en,
  output logic                   sleeping
);
  logic         boot_done;
  logic         divide_change_unlock;
  logic [1:0]   unlock_left;
  logic [3:0]   divide_select;
  logic         sel_load;
  logic         sleep_allow;
  logic [1:0]   sleep_mode_select;
  logic [1:0]   active_mode;
  scpts_state_t state;
  scpts_state_t next_state;
  logic [2:0]   halt_left;
  logic         wake_req;
  logic         div_tick;
  logic         wr_div;
  logic         wr_trim;
  logic         wr_sleep;
  logic         unlock_req;
  logic         select_req;
  logic         select_legal;
  logic         domain_cpu;
  logic         domain_flash;
  logic         domain_io;
  logic         domain_adc;
  logic         domain_osc;

  assign wr_div       = wr && (addr == DIV_CTRL_OFFS);
  assign wr_trim      = wr && (addr == TRIM_OFFS);
  assign wr_sleep     = wr && (addr == SLEEP_CTRL_OFFS);
  assign unlock_req   = wr_div && (wdata == UNLOCK_PATTERN);
  assign select_req   = wr_div && !wdata[UNLOCK_BIT];
  assign select_legal = (wdata[SEL_W-1:0] <= SEL_MAX);

  // Straps and factory value are caught on the first edge after release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      boot_done <= 1'b0;
    end else begin
      boot_done <= 1'b1;
    end
  end

  // Trim register; bit 7 is range, 6..0 fine value
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rc_osc_trim <= TRIM_RESET;
    end else if (!boot_done) begin
      rc_osc_trim <= factory_trim;
    end else if (wr_trim) begin
      rc_osc_trim <= wdata; // Drives the oscillator directly
    end
  end

  // Unlock window: four cycles from set, not restartable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      divide_change_unlock <= 1'b0;
      unlock_left          <= '0;
    end else if (divide_change_unlock) begin
      if (select_req || unlock_left == 2'h0) begin
        divide_change_unlock <= 1'b0;
      end else begin
        unlock_left <= unlock_left - 2'h1;
      end
    end else if (unlock_req) begin
      divide_change_unlock <= 1'b1;
      unlock_left          <= UNLOCK_CYCLES_M1;
    end
  end

  // Select field, guarded by the unlock window
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      divide_select <= SEL_FUSE_OFF;
      sel_load      <= 1'b0;
    end else if (!boot_done) begin
      divide_select <= boot_divide_by_eight_fuse ? SEL_FUSE_ON
                                                 : SEL_FUSE_OFF;
      sel_load      <= 1'b1;
    end else if (divide_change_unlock && select_req && select_legal) begin
      divide_select <= wdata[SEL_W-1:0];
      sel_load      <= 1'b1;
    end else begin
      // Reserved codes dropped; window still closes above
      sel_load      <= 1'b0;
    end
  end

  scpts_divider #(
    .SW (SEL_W),
    .CW (DIV_CNT_W)
  ) u_divider (
    .clock    (clock),
    .rst      (rst),
    .sel      (divide_select),
    .sel_load (sel_load),
    .tick     (div_tick)
  );

  // Every domain advances on the divided tick only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sys_tick <= 1'b0;
    end else begin
      sys_tick <= div_tick;
    end
  end

  // Sleep control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sleep_allow       <= 1'b0;
      sleep_mode_select <= MODE_IDLE;
    end else if (wr_sleep) begin
      sleep_allow       <= wdata[SLEEP_ALLOW_BIT];
      sleep_mode_select <= wdata[SLEEP_MODE_LSB +: 2];
    end
  end

  scpts_wake u_wake (
    .clock      (clock),
    .rst        (rst),
    .mode       (active_mode),
    .irq_level  (external_irq_line && irq_level_mode),
    .irq_edge   (external_irq_line && !irq_level_mode),
    .pin_change (pin_change_wake),
    .watchdog   (watchdog_wake),
    .nvm_ready  (nvm_ready_wake),
    .adc_done   (adc_done_wake),
    .other_io   (other_io_wake),
    .wake       (wake_req)
  );

  always_comb begin
    case (state)
      SCPTS_AWAKE: begin
        if (sleep_instr && sleep_allow) begin
          next_state = SCPTS_SLEEPING;
        end else begin
          next_state = SCPTS_AWAKE;
        end
      end
      SCPTS_SLEEPING: begin
        next_state = wake_req ? SCPTS_WAKING : SCPTS_SLEEPING;
      end
      SCPTS_WAKING: begin
        next_state = (halt_left == 3'h0) ? SCPTS_AWAKE : SCPTS_WAKING;
      end
      default: begin
        next_state = SCPTS_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= SCPTS_AWAKE;
    end else begin
      state <= next_state;
    end
  end

  // Mode latched at entry so later writes cannot change a sleep
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      active_mode <= MODE_IDLE;
    end else if (state == SCPTS_AWAKE) begin
      active_mode <= sleep_mode_select;
    end
  end

  // CPU held a few cycles after wake-up
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      halt_left <= '0;
    end else if (state == SCPTS_SLEEPING) begin
      halt_left <= WAKE_HALT_CYCLES - 3'h1;
    end else if (halt_left != 3'h0) begin
      halt_left <= halt_left - 3'h1;
    end
  end

  // Domain gating per mode
  always_comb begin
    domain_cpu   = 1'b1;
    domain_flash = 1'b1;
    domain_io    = 1'b1;
    domain_adc   = 1'b1;
    domain_osc   = 1'b1;
    if (state == SCPTS_SLEEPING) begin
      domain_cpu   = 1'b0;
      domain_flash = 1'b0;
      case (active_mode)
        MODE_IDLE: begin
          domain_io = 1'b1;
        end
        MODE_NOISE: begin
          domain_io = 1'b0;
        end
        MODE_PDOWN: begin
          domain_io  = 1'b0;
          domain_adc = 1'b0;
          domain_osc = 1'b0;
        end
        MODE_STANDBY: begin
          // Oscillator kept for the fast standby restart
          domain_io  = 1'b0;
          domain_adc = 1'b0;
        end
        default: begin
          domain_io = 1'b0;
        end
      endcase
    end else if (state == SCPTS_WAKING) begin
      domain_cpu   = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpu_clk_en   <= 1'b1;
      flash_clk_en <= 1'b1;
      io_clk_en    <= 1'b1;
      adc_clk_en   <= 1'b1;
      osc_en       <= 1'b1;
      sleeping     <= 1'b0;
    end else begin
      cpu_clk_en   <= domain_cpu;
      flash_clk_en <= domain_flash;
      io_clk_en    <= domain_io;
      adc_clk_en   <= domain_adc;
      osc_en       <= domain_osc;
      sleeping     <= (state == SCPTS_SLEEPING);
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        DIV_CTRL_OFFS: begin
          rdata <= {divide_change_unlock, 3'h0, divide_select};
        end
        TRIM_OFFS: begin
          rdata <= rc_osc_trim;
        end
        SLEEP_CTRL_OFFS: begin
          rdata <= {2'h0, sleep_allow, sleep_mode_select, 3'h0};
        end
        CLK_STATUS_OFFS: begin
          rdata <= {2'h0, sleeping, osc_en, adc_clk_en, io_clk_en,
                    flash_clk_en, cpu_clk_en};
        end
        default: begin
          rdata <= '0;
        end
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule : scpts_clock_control

// *** rtl/scpts_divider.sv ***
`timescale 1ns/100ps
module scpts_divider
  import scpts_pkg::*;
#(
  parameter int SW = SEL_W,
  parameter int CW = DIV_CNT_W
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic [SW-1:0] sel,
  input  wire logic          sel_load,
  output logic               tick
);
  logic [SW-1:0] active_sel;
  logic [SW-1:0] pend_sel;
  logic          pend;
  logic [CW-1:0] cnt;
  logic          boundary;

  function automatic logic [CW-1:0] scpts_mask(input logic [SW-1:0] s);
    logic [CW-1:0] m;
    m = '0;
    for (int i = 0; i < CW; i++) begin
      if (i < int'(s)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : scpts_mask

  // End of the current divided period
  assign boundary = ((cnt & scpts_mask(active_sel))
                     == scpts_mask(active_sel));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend     <= 1'b0;
      pend_sel <= '0;
    end else if (sel_load) begin
      pend     <= 1'b1;
      pend_sel <= sel;
    end else if (boundary) begin
      pend     <= 1'b0;
    end
  end

  // Switch only at an old-period boundary: no short period
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      active_sel <= '0;
      cnt        <= '0;
    end else if (boundary && pend && !sel_load) begin
      active_sel <= pend_sel;
      cnt        <= '0;
    end else begin
      cnt        <= cnt + 1'b1;
    end
  end

  // One enable pulse per divided period, 2^n master cycles
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= boundary;
    end
  end
endmodule : scpts_divider

// *** rtl/scpts_pkg.sv ***
// Contract
// - Factory trim value is loaded into the oscillator trim register at reset.
// - Software may rewrite the trim register any time; it retunes at once.
// - Trim top bit selects low or high range; ranges overlap.
// - Lower seven trim bits tune monotonically inside the selected range.
// - Divide control bits 6..4 read zero and ignore writes.
// - Unlock bit sets only on a write of unlock one, all else zero.
// - Unlock clears four cycles after set, or at a select write.
// - Rewriting unlock while set neither restarts the window nor clears it.
// - Select changes only via unlock write then select write within four.
// - Select n of 0..8 divides master clock by two to the n.
// - Reset select is 0000, or 0011 when the divide-by-eight fuse is set.
// - Any legal select can be written after reset regardless of fuse.
// - The division slows CPU and all synchronous peripheral clocks.
// - Idle stops CPU, flash; noise keeps ADC, oscillator; deep stops all. Standby here keeps the oscillator running.
// - Noise and deep sleep wake only on level irq, pin change, watchdog. Noise here also wakes on nvm ready and ADC done.
// - Sleep entered by allow bit plus sleep instruction; mode field 00..11.
// - Division change gives no glitch nor a period shorter than either.
// - New division active between T1+T2 and T1+2xT2 after the write.
package scpts_pkg;
  localparam int         ADDR_W           = 8;
  localparam int         DATA_W           = 8;
  localparam int         SEL_W            = 4;
  localparam int         DIV_CNT_W        = 8;
  localparam logic [7:0] DIV_CTRL_OFFS    = 8'h26;
  localparam logic [7:0] TRIM_OFFS        = 8'h31;
  localparam logic [7:0] SLEEP_CTRL_OFFS  = 8'h35;
  localparam logic [7:0] CLK_STATUS_OFFS  = 8'h36;
  localparam int         UNLOCK_BIT       = 7;
  localparam logic [7:0] UNLOCK_PATTERN   = 8'h80;
  localparam logic [1:0] UNLOCK_CYCLES_M1 = 2'h3;
  localparam logic [3:0] SEL_FUSE_OFF     = 4'h0;
  localparam logic [3:0] SEL_FUSE_ON      = 4'h3;
  localparam logic [3:0] SEL_MAX          = 4'h8;
  localparam logic [7:0] TRIM_RESET       = 8'h80;
  localparam int         SLEEP_ALLOW_BIT  = 5;
  localparam int         SLEEP_MODE_LSB   = 3;
  localparam logic [2:0] WAKE_HALT_CYCLES = 3'h4;
  localparam logic [1:0] MODE_IDLE        = 2'h0;
  localparam logic [1:0] MODE_NOISE       = 2'h1;
  localparam logic [1:0] MODE_PDOWN       = 2'h2;
  localparam logic [1:0] MODE_STANDBY     = 2'h3;
  typedef enum logic [1:0] {
    SCPTS_AWAKE    = 2'b00,
    SCPTS_SLEEPING = 2'b01,
    SCPTS_WAKING   = 2'b11
  } scpts_state_t;
endpackage : scpts_pkg

// *** rtl/scpts_wake.sv ***
`timescale 1ns/100ps
module scpts_wake
  import scpts_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [1:0] mode,
  input  wire logic       irq_level,
  input  wire logic       irq_edge,
  input  wire logic       pin_change,
  input  wire logic       watchdog,
  input  wire logic       nvm_ready,
  input  wire logic       adc_done,
  input  wire logic       other_io,
  output logic            wake
);
  logic next_wake;

  always_comb begin
    case (mode)
      MODE_IDLE: begin
        next_wake = irq_level | irq_edge | pin_change | watchdog
                    | nvm_ready | adc_done | other_io;
      end
      MODE_NOISE: begin
        // Edge irq needs the io clock, which is stopped here
        next_wake = irq_level | pin_change | watchdog | nvm_ready
                    | adc_done;
      end
      MODE_PDOWN, MODE_STANDBY: begin
        next_wake = irq_level | pin_change | watchdog;
      end
      default: begin
        next_wake = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake <= 1'b0;
    end else begin
      wake <= next_wake;
    end
  end
endmodule : scpts_wake

// *** testbench/scpts_clock_control_monitor.sv ***
`timescale 1ns/100ps
module scpts_clock_control_monitor
  import scpts_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [7:0]        factory_trim,
  input wire logic              sleep_instr,
  input wire logic              external_irq_line,
  input wire logic              irq_level_mode,
  input wire logic              pin_change_wake,
  input wire logic              watchdog_wake,
  input wire logic [7:0]        rc_osc_trim,
  input wire logic              cpu_clk_en,
  input wire logic              flash_clk_en,
  input wire logic              io_clk_en,
  input wire logic              adc_clk_en,
  input wire logic              osc_en,
  input wire logic              sleeping
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_trim_factory: assert property ($past(rst) && !rst |=>
    rc_osc_trim == $past(factory_trim)) else $error("trim not factory");
  a_trim_write: assert property (wr && addr == TRIM_OFFS && !$past(rst)
    |=> rc_osc_trim == $past(wdata)) else $error("trim write lost");
  a_rsvd_zero: assert property (rd && addr == DIV_CTRL_OFFS
    |=> rdata[6:4] == 3'h0) else $error("reserved bits set");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside slot");
  a_cpu_gated: assert property (sleeping |->
    !cpu_clk_en && !flash_clk_en)
    else $error("cpu clock runs in sleep");
  a_io_needs_adc: assert property (io_clk_en |-> adc_clk_en)
    else $error("io clock without adc clock");
  a_adc_needs_osc: assert property (adc_clk_en |-> osc_en)
    else $error("adc clock without oscillator");
  a_sleep_entry: assert property ($rose(sleeping) |->
    $past(sleep_instr) || $past(sleep_instr, 2) ||
    $past(sleep_instr, 3) || $past(sleep_instr, 4))
    else $error("sleep without instruction");
  // Deep modes: only level irq, pin change or watchdog may end sleep
  a_deep_holds: assert property ((sleeping && !adc_clk_en &&
    !pin_change_wake && !watchdog_wake &&
    !(external_irq_line && irq_level_mode))[*4] |=> sleeping)
    else $error("deep sleep left without source");
endmodule : scpts_clock_control_monitor

bind scpts_clock_control scpts_clock_control_monitor mon (.*);

// *** testbench/scpts_clock_control_tb_top.sv ***
`timescale 1ns/100ps
module scpts_clock_control_tb_top;
  import scpts_pkg::*;
  logic       clock, rst, wr, rd, fuse, sleep_instr;
  logic [7:0] addr, wdata, rdata, factory_trim, rc_osc_trim;
  logic       external_irq_line, irq_level_mode, pin_change_wake;
  logic       watchdog_wake, nvm_ready_wake, adc_done_wake, other_io_wake;
  logic       sys_tick, cpu_clk_en, flash_clk_en, io_clk_en;
  logic       adc_clk_en, osc_en, sleeping;
  logic [4:0] e;
  // Expected {cpu, flash, io, adc, osc} per sleep mode
  logic [4:0] exp_en [4] = '{5'h07, 5'h03, 5'h00, 5'h01};
  int         miscompares, tests_run, g, i, m, n;

  scpts_clock_control dut (.boot_divide_by_eight_fuse(fuse), .*);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task stop_test;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Strobe left high so writes can follow with no gap
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clock);
  endtask : wr_reg

  task idle;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock);
  endtask : idle

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    check(rdata, exp);
    @(posedge clock);
  endtask : rd_chk

  // Cycles between two sys_tick pulses, sampled away from the edge
  task gap(output int gv);
    int k;
    @(negedge clock);
    for (k = 0; k < 600 && sys_tick !== 1'b1; k++) @(negedge clock);
    gv = 0;
    do begin
      @(negedge clock);
      gv++;
    end while (sys_tick !== 1'b1 && gv < 600);
  endtask : gap

  initial begin
    #200000;
    miscompares++;
    stop_test();
  end

  initial begin
    {wr, rd, sleep_instr, external_irq_line, irq_level_mode} = 5'h00;
    {pin_change_wake, watchdog_wake, nvm_ready_wake} = 3'h0;
    {adc_done_wake, other_io_wake, addr, wdata} = 18'h00000;
    rst = 1'b1;
    fuse = 1'b1;
    factory_trim = 8'h5a;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    rd_chk(TRIM_OFFS, 8'h5a);
    rd_chk(DIV_CTRL_OFFS, 8'h03);
    foreach (exp_en[j]) begin
      // No nonvolatile writes run while the trim is swept high
      wr_reg(TRIM_OFFS, 8'h7f << (2 * j));
      rd_chk(TRIM_OFFS, 8'h7f << (2 * j));
      check(rc_osc_trim, 8'(8'h7f << (2 * j)));
    end
    rd_chk(8'h10, 8'h00);
    wr_reg(DIV_CTRL_OFFS, UNLOCK_PATTERN);
    rd_chk(DIV_CTRL_OFFS, 8'h83);
    wr_reg(DIV_CTRL_OFFS, 8'h05);
    rd_chk(DIV_CTRL_OFFS, 8'h05);
    wr_reg(DIV_CTRL_OFFS, 8'h81);
    wr_reg(DIV_CTRL_OFFS, 8'h02);
    rd_chk(DIV_CTRL_OFFS, 8'h05);
    wr_reg(DIV_CTRL_OFFS, UNLOCK_PATTERN);
    repeat (4) idle();
    wr_reg(DIV_CTRL_OFFS, 8'h02);
    rd_chk(DIV_CTRL_OFFS, 8'h05);
    wr_reg(DIV_CTRL_OFFS, UNLOCK_PATTERN);
    repeat (2) idle();
    wr_reg(DIV_CTRL_OFFS, UNLOCK_PATTERN);
    repeat (2) idle();
    wr_reg(DIV_CTRL_OFFS, 8'h02);
    rd_chk(DIV_CTRL_OFFS, 8'h05);
    wr_reg(DIV_CTRL_OFFS, UNLOCK_PATTERN);
    wr_reg(DIV_CTRL_OFFS, UNLOCK_PATTERN);
    wr_reg(DIV_CTRL_OFFS, 8'h02);
    wr_reg(DIV_CTRL_OFFS, 8'h06);
    rd_chk(DIV_CTRL_OFFS, 8'h02);
    wr_reg(DIV_CTRL_OFFS, UNLOCK_PATTERN);
    wr_reg(DIV_CTRL_OFFS, 8'h0c);
    wr_reg(DIV_CTRL_OFFS, 8'h01);
    rd_chk(DIV_CTRL_OFFS, 8'h02);
    for (n = 0; n <= 8; n++) begin
      // Back to back, nothing may slip between the two writes
      wr_reg(DIV_CTRL_OFFS, UNLOCK_PATTERN);
      wr_reg(DIV_CTRL_OFFS, 8'(n));
      idle();
      gap(g);
      gap(g);
      check(g, 1 << n);
      @(posedge clock);
    end
    // Without the allow bit the instruction must not sleep
    wr_reg(SLEEP_CTRL_OFFS, 8'h00);
    idle();
    sleep_instr <= 1'b1;
    @(posedge clock);
    sleep_instr <= 1'b0;
    repeat (4) @(negedge clock);
    check(sleeping, 1'b0);
    @(posedge clock);
    for (m = 0; m < 4; m++) begin
      wr_reg(SLEEP_CTRL_OFFS, 8'h20 | (8'(m) << SLEEP_MODE_LSB));
      idle();
      sleep_instr <= 1'b1;
      @(posedge clock);
      sleep_instr <= 1'b0;
      repeat (4) @(negedge clock);
      e = exp_en[m];
      check({cpu_clk_en, flash_clk_en, io_clk_en, adc_clk_en, osc_en},
            e);
      @(posedge clock);
      rd_chk(CLK_STATUS_OFFS, {3'h1, e[0], e[1], e[2], e[3], e[4]});
      case (m)
        0: other_io_wake <= 1'b1;
        1: external_irq_line <= 1'b1;
        2: irq_level_mode <= 1'b1;
        default: pin_change_wake <= 1'b1;
      endcase
      if (m == 1) begin
        repeat (8) @(negedge clock);
        check(sleeping, 1'b1);
        @(posedge clock);
        adc_done_wake <= 1'b1;
      end
      for (i = 0; i < 40 && cpu_clk_en !== 1'b1; i++) @(negedge clock);
      check({cpu_clk_en, sleeping}, 2'h2);
      @(posedge clock);
      {other_io_wake, adc_done_wake, pin_change_wake} <= 3'h0;
      irq_level_mode <= 1'b0;
      external_irq_line <= (m == 1);
      repeat (2) @(posedge clock);
    end
    rst <= 1'b1;
    fuse <= 1'b0;
    factory_trim <= 8'h3c;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    rd_chk(DIV_CTRL_OFFS, 8'h00);
    check(rc_osc_trim, 8'h3c);
    stop_test();
  end
endmodule : scpts_clock_control_tb_top
